// ### verif/restart_interlock_reset_timer_test.sv
// Self-checking bench of the restart interlock reset timer
`timescale 1ns/1ns
`default_nettype none
`include "rilrt_cfg.svh"
module restart_interlock_reset_timer_test;
	// Short tick keeps the long press inside the run budget
	localparam int TK = 20;
	typedef struct {int ticks; logic on;} rilrt_row_t;
	rilrt_row_t rows [3] = '{'{140, 1'b0}, '{160, 1'b1}, '{250, 1'b1}};
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic field_clear, pressed, bridged, pin_level, lock_cfg, lamp_out, lamp_oe_n;
	logic ssa, ssb, green, red, yellow, irq;
	int mismatches, samples_checked;

	rilrt_top #(.TICK_CYCLES(TK)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .field_clear(field_clear),
		.restart_lock_config_input(lock_cfg), .button_in_lamp_out_pin_in(pin_level),
		.button_in_lamp_out_pin_out(lamp_out), .button_in_lamp_out_pin_oe_n(lamp_oe_n),
		.safety_switch_output_a(ssa), .safety_switch_output_b(ssb), .main_status_indicator(green),
		.lock_red_indicator(red), .ready_yellow_indicator(yellow), .irq(irq));

	rilrt_button_model partner (.pressed(pressed), .bridged(bridged), .lamp_out(lamp_out),
		.lamp_oe_n(lamp_oe_n), .pin_level(pin_level), .lock_cfg(lock_cfg));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// ----
	// Helpers
	// ----
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Ready is looked at mid-cycle, where it is settled, and acted on at the next edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ta, tw, b;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			b = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!b);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ta, b;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			b = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!b);
	endtask

	task automatic chk_out(input logic on, input logic y);
		@(negedge aclk);
		chk(32'(ssa), 32'(on));
		chk(32'(ssb), 32'(on));
		chk(32'(green), 32'(on));
		chk(32'(red), 32'(!on));
		chk(32'(yellow), 32'(y));
		while (lamp_oe_n) @(negedge aclk);
		chk(32'(lamp_out), 32'(!on));
	endtask

	task automatic press(input int t);
		pressed <= 1'b1;
		wt(t * TK);
		pressed <= 1'b0;
		wt(3 * TK);
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		mismatches = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		{field_clear, pressed, bridged, awvalid, wvalid, arvalid} = 6'h00;
		{bready, rready} = 2'h3;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		wt(16);
		aresetn <= 1'b1;
		chk_out(1'b0, 1'b0);
		wt(1);
		axi_rd(`RILRT_OFS_IRQ_MASK, d, r);
		chk(d, 32'h0);
		axi_rd(8'hF0, d, r);
		chk(32'(r), 32'(`RILRT_RESP_SLVERR));
		axi_wr(8'hF0, 32'hF, r);
		chk(32'(r), 32'(`RILRT_RESP_SLVERR));
		axi_wr(`RILRT_OFS_IRQ_MASK, 32'hF, r);
		wt(2 * TK);
		field_clear <= 1'b1;
		wt(3);
		chk_out(1'b0, 1'b1);
		foreach (rows[i]) begin
			wt(1);
			field_clear <= 1'b0;
			wt(TK);
			field_clear <= 1'b1;
			wt(TK);
			press(rows[i].ticks);
			chk_out(rows[i].on, !rows[i].on);
		end
		chk(32'(irq), 32'h1);
		wt(1);
		axi_wr(`RILRT_OFS_IRQ_STAT, 32'hF, r);
		wt(2);
		chk(32'(irq), 32'h0);
		field_clear <= 1'b0;
		wt(3);
		chk_out(1'b0, 1'b0);
		wt(1);
		axi_rd(`RILRT_OFS_IRQ_STAT, d, r);
		chk(d, 32'(1 << `RILRT_IRQ_TRIP));
		axi_wr(`RILRT_OFS_IRQ_STAT, 32'hF, r);
		field_clear <= 1'b1;
		wt(3 * TK);
		chk_out(1'b0, 1'b1);
		wt(1);
		press(4010);
		chk_out(1'b0, 1'b1);
		wt(1);
		axi_rd(`RILRT_OFS_IRQ_STAT, d, r);
		chk(d & 32'h4, 32'h4);
		press(200);
		chk_out(1'b1, 1'b0);
		wt(1);
		axi_rd(`RILRT_OFS_PRESS, d, r);
		chk(d, 32'hC8);
		wt(1);
		axi_wr(`RILRT_OFS_IRQ_MASK, 32'h0, r);
		wt(2);
		chk(32'(irq), 32'h0);
		bridged <= 1'b1;
		field_clear <= 1'b0;
		wt(3 * TK);
		field_clear <= 1'b1;
		wt(3 * TK);
		chk_out(1'b1, 1'b0);
		wt(1);
		axi_wr(`RILRT_OFS_CTRL, 32'h1, r);
		field_clear <= 1'b0;
		wt(3);
		field_clear <= 1'b1;
		wt(3 * TK);
		chk_out(1'b0, 1'b1);
		wt(1);
		axi_rd(`RILRT_OFS_STATUS, d, r);
		chk(d, 32'h18);
		summarize;
	end

	initial begin
		wt(100000);
		mismatches++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		summarize;
	end
endmodule // restart_interlock_reset_timer_test
`default_nettype wire

// ### verif/rilrt_button_model.sv
// Operator button, lamp wiring and lock configuration model
`timescale 1ns/1ns
`default_nettype none
module rilrt_button_model (
	input wire logic pressed,
	input wire logic bridged,
	input wire logic lamp_out,
	input wire logic lamp_oe_n,
	output logic pin_level,
	output logic lock_cfg
);
	// Pressed contact ties the pin high even against the lamp driver
	assign pin_level = pressed | (!lamp_oe_n & lamp_out);
	// Bridged to the button pin the lock input only sees the pin
	assign lock_cfg = bridged ? pin_level : 1'b1;
endmodule // rilrt_button_model
`default_nettype wire

// ### verilog/rilrt_cfg.svh
// Constants of the restart interlock reset timer
// Operation
// - After a protective trip or power-up with the restart lock enabled, both safety outputs stay off until a valid reset unlocks them.
// - The red indicator is lit for as long as the safety outputs are held off.
// - The yellow indicator is lit while the field is clear and the restart lock is enabled and pending.
// - A press lasting 0.15 s to under 4 s that ends with release unlocks to the ON state.
// - A press that has lasted 4 s is discarded, even when released later.
// - A reset input held for 30 s without a break counts as stuck high and forces the fault interlock.
// - With a clear field and no lock pending, green is lit and both safety outputs are on.
// - The combined pin reads the button as reset request and drives the lamp as the inverse of the outputs.
`ifndef RILRT_CFG_SVH
`define RILRT_CFG_SVH

// ----------------------------------------
// Time base
// ----------------------------------------
`define RILRT_CLK_MHZ 250
`define RILRT_TICK_MS 1
`define RILRT_TICK_CYCLES ((`RILRT_TICK_MS) * 1000 * (`RILRT_CLK_MHZ))
`define RILRT_SLOT_CYCLES 16
`define RILRT_TICK_CW 20

// ----------------------------------------
// Press limits
// ----------------------------------------
`define RILRT_MIN_PRESS_MS 150
`define RILRT_MAX_PRESS_MS 4000
`define RILRT_STUCK_MS 30000
`define RILRT_MIN_PRESS_TICKS ((`RILRT_MIN_PRESS_MS + `RILRT_TICK_MS - 1) / `RILRT_TICK_MS)
`define RILRT_MAX_PRESS_TICKS (`RILRT_MAX_PRESS_MS / `RILRT_TICK_MS)
`define RILRT_STUCK_TICKS (`RILRT_STUCK_MS / `RILRT_TICK_MS)
`define RILRT_PRESS_W 15

// ----------------------------------------
// Register map
// ----------------------------------------
`define RILRT_AW 8
`define RILRT_OFS_CTRL 8'h00
`define RILRT_OFS_STATUS 8'h04
`define RILRT_OFS_IRQ_STAT 8'h08
`define RILRT_OFS_IRQ_MASK 8'h0C
`define RILRT_OFS_PRESS 8'h10
`define RILRT_RESP_OKAY 2'h0
`define RILRT_RESP_SLVERR 2'h2
`define RILRT_CTRL_FORCE_BIT 0
`define RILRT_IRQ_W 4
`define RILRT_IRQ_TRIP 0
`define RILRT_IRQ_UNLOCK 1
`define RILRT_IRQ_IGNORED 2
`define RILRT_IRQ_FAULT 3
`define RILRT_ST_SAFETY_SWITCH_OUTPUT_BIT 2
`define RILRT_ST_LOCKEN_BIT 3
`define RILRT_ST_FIELD_BIT 4
`define RILRT_ST_BTN_BIT 5

`endif

// ### verilog/rilrt_pkg.sv
// Types of the restart interlock reset timer
`include "rilrt_cfg.svh"
package rilrt_pkg;
	typedef enum logic [1:0] {RILRT_LOCKED, RILRT_ON, RILRT_FAULT} rilrt_state_t;

	typedef struct packed {
		rilrt_state_t state;
		logic btn_s1;
		logic btn_s2;
		logic cfg_s1;
		logic cfg_s2;
		logic btn;
		logic cfg;
		logic [`RILRT_PRESS_W-1:0] press;
		logic [`RILRT_PRESS_W-1:0] last_press;
		logic safety_switch_output;
		logic yellow;
		logic ctrl_force;
		logic [`RILRT_IRQ_W-1:0] irq_stat;
		logic [`RILRT_IRQ_W-1:0] irq_mask;
		logic aw_ok;
		logic [`RILRT_AW-1:0] awaddr;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rilrt_top_st_t;

	typedef struct packed {
		logic [`RILRT_TICK_CW-1:0] cnt;
	} rilrt_tick_st_t;
endpackage

// ### verilog/rilrt_tick.sv
// Millisecond time base and pin release slot
`timescale 1ns/1ns
`default_nettype none
`include "rilrt_cfg.svh"
module rilrt_tick #(
	parameter int TICK_CYCLES = `RILRT_TICK_CYCLES,
	parameter int SLOT_CYCLES = `RILRT_SLOT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic tick,
	output logic release_slot
);
	import rilrt_pkg::*;

	rilrt_tick_st_t st_ff;
	rilrt_tick_st_t nxt_st;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (st_ff.cnt == `RILRT_TICK_CW'(TICK_CYCLES - 1)) begin
			nxt_st.cnt = '0;
		end else begin
			nxt_st.cnt = st_ff.cnt + `RILRT_TICK_CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Sample at the slot end, after the synchroniser has settled
	assign tick = (st_ff.cnt == `RILRT_TICK_CW'(TICK_CYCLES - 1));
	assign release_slot = (st_ff.cnt >= `RILRT_TICK_CW'(TICK_CYCLES - SLOT_CYCLES));
endmodule // rilrt_tick
`default_nettype wire

// ### verilog/rilrt_top.sv
// Restart interlock with reset button timer and AXI4-Lite registers
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "rilrt_cfg.svh"
module rilrt_top #(
	parameter int TICK_CYCLES = `RILRT_TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`RILRT_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`RILRT_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic field_clear,
	input wire logic restart_lock_config_input,
	input wire logic button_in_lamp_out_pin_in,
	output logic button_in_lamp_out_pin_out,
	output logic button_in_lamp_out_pin_oe_n,
	output logic safety_switch_output_a,
	output logic safety_switch_output_b,
	output logic main_status_indicator,
	output logic lock_red_indicator,
	output logic ready_yellow_indicator,
	output logic irq
);
	import rilrt_pkg::*;

	localparam int PW = `RILRT_PRESS_W;
	localparam logic [PW-1:0] MIN_T = PW'(`RILRT_MIN_PRESS_TICKS);
	localparam logic [PW-1:0] MAX_T = PW'(`RILRT_MAX_PRESS_TICKS);
	localparam logic [PW-1:0] STUCK_T = PW'(`RILRT_STUCK_TICKS);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (TICK_CYCLES <= `RILRT_SLOT_CYCLES + 2 || TICK_CYCLES > (1 << `RILRT_TICK_CW)) begin : g_bad_tick
		$error("tick period out of range");
	end
	if (`RILRT_STUCK_TICKS >= (1 << `RILRT_PRESS_W)) begin : g_bad_press
		$error("press counter too narrow");
	end

	// Register index, shared by read and write decode
	function automatic logic [2:0] reg_idx(input logic [`RILRT_AW-1:0] a);
		unique case (a)
			`RILRT_OFS_CTRL: reg_idx = 3'h0;
			`RILRT_OFS_STATUS: reg_idx = 3'h1;
			`RILRT_OFS_IRQ_STAT: reg_idx = 3'h2;
			`RILRT_OFS_IRQ_MASK: reg_idx = 3'h3;
			`RILRT_OFS_PRESS: reg_idx = 3'h4;
			default: reg_idx = 3'h7;
		endcase
	endfunction

	rilrt_top_st_t st_ff;
	rilrt_top_st_t nxt_st;
	logic tick;
	logic release_slot;
	logic lock_en;
	logic valid_press;
	logic ignored_press;
	logic stuck;
	logic [`RILRT_IRQ_W-1:0] irq_set;
	logic [`RILRT_IRQ_W-1:0] irq_clr;
	logic do_write;

	rilrt_tick #(
		.TICK_CYCLES(TICK_CYCLES),
		.SLOT_CYCLES(`RILRT_SLOT_CYCLES)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick),
		.release_slot(release_slot)
	);

	// Software may force the lock on, never off
	assign lock_en = st_ff.cfg | st_ff.ctrl_force;
	assign valid_press = tick && !st_ff.btn && st_ff.press >= MIN_T && st_ff.press < MAX_T;
	assign ignored_press = tick && !st_ff.btn && st_ff.press >= MAX_T;
	assign stuck = tick && st_ff.btn && st_ff.press == STUCK_T - PW'(1);
	assign do_write = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		irq_set = '0;
		irq_clr = '0;
		// Two-flop synchronisers for the pins
		nxt_st.btn_s1 = button_in_lamp_out_pin_in;
		nxt_st.btn_s2 = st_ff.btn_s1;
		nxt_st.cfg_s1 = restart_lock_config_input;
		nxt_st.cfg_s2 = st_ff.cfg_s1;
		if (tick) begin
			// Pin is released here, so the lamp does not mask the button
			nxt_st.btn = st_ff.btn_s2;
			nxt_st.cfg = st_ff.cfg_s2;
			if (st_ff.btn) begin
				if (st_ff.press != STUCK_T) begin
					nxt_st.press = st_ff.press + PW'(1);
				end
			end else begin
				if (st_ff.press != '0) begin
					nxt_st.last_press = st_ff.press;
				end
				nxt_st.press = '0;
			end
		end
		if (ignored_press) begin
			irq_set[`RILRT_IRQ_IGNORED] = 1'b1;
		end
		unique case (st_ff.state)
			RILRT_LOCKED: begin
				if (stuck) begin
					nxt_st.state = RILRT_FAULT;
					irq_set[`RILRT_IRQ_FAULT] = 1'b1;
				end else if (!lock_en) begin
					nxt_st.state = RILRT_ON;
				end else if (valid_press && field_clear) begin
					nxt_st.state = RILRT_ON;
					irq_set[`RILRT_IRQ_UNLOCK] = 1'b1;
				end
			end
			RILRT_ON: begin
				if (stuck) begin
					nxt_st.state = RILRT_FAULT;
					irq_set[`RILRT_IRQ_FAULT] = 1'b1;
				end else if (!field_clear && lock_en) begin
					nxt_st.state = RILRT_LOCKED;
					irq_set[`RILRT_IRQ_TRIP] = 1'b1;
				end
			end
			RILRT_FAULT: begin
				// Only a reset leaves the fault interlock
				nxt_st.state = RILRT_FAULT;
			end
		endcase
		nxt_st.safety_switch_output = (st_ff.state == RILRT_ON) && field_clear && !stuck;
		nxt_st.yellow = field_clear && lock_en && st_ff.state == RILRT_LOCKED;

		// AXI4-Lite write
		if (s_axi_awvalid && !st_ff.aw_ok) begin
			nxt_st.aw_ok = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.w_ok) begin
			nxt_st.w_ok = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_st.aw_ok = 1'b0;
			nxt_st.w_ok = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = `RILRT_RESP_OKAY;
			unique case (reg_idx(st_ff.awaddr))
				3'h0: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.ctrl_force = st_ff.wdata[`RILRT_CTRL_FORCE_BIT];
					end
				end
				3'h2: begin
					if (st_ff.wstrb[0]) begin
						irq_clr = st_ff.wdata[`RILRT_IRQ_W-1:0];
					end
				end
				3'h3: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.irq_mask = st_ff.wdata[`RILRT_IRQ_W-1:0];
					end
				end
				3'h1, 3'h4: begin
				end
				default: nxt_st.bresp = `RILRT_RESP_SLVERR;
			endcase
		end else if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Set beats a same-cycle clear
		nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_set;

		// AXI4-Lite read
		if (s_axi_arvalid && !st_ff.rvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = `RILRT_RESP_OKAY;
			nxt_st.rdata = '0;
			unique case (reg_idx(s_axi_araddr))
				3'h0: nxt_st.rdata[`RILRT_CTRL_FORCE_BIT] = st_ff.ctrl_force;
				3'h1: begin
					nxt_st.rdata[1:0] = st_ff.state;
					nxt_st.rdata[`RILRT_ST_SAFETY_SWITCH_OUTPUT_BIT] = st_ff.safety_switch_output;
					nxt_st.rdata[`RILRT_ST_LOCKEN_BIT] = lock_en;
					nxt_st.rdata[`RILRT_ST_FIELD_BIT] = field_clear;
					nxt_st.rdata[`RILRT_ST_BTN_BIT] = st_ff.btn;
				end
				3'h2: nxt_st.rdata[`RILRT_IRQ_W-1:0] = st_ff.irq_stat;
				3'h3: nxt_st.rdata[`RILRT_IRQ_W-1:0] = st_ff.irq_mask;
				3'h4: nxt_st.rdata[PW-1:0] = st_ff.last_press;
				default: nxt_st.rresp = `RILRT_RESP_SLVERR;
			endcase
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	// Reset lands in the locked state: power loss counts as a trip
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			// Lock assumed on until the config pin is first sampled
			st_ff.cfg <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = !st_ff.aw_ok;
	assign s_axi_wready = !st_ff.w_ok;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = !st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign safety_switch_output_a = st_ff.safety_switch_output;
	assign safety_switch_output_b = st_ff.safety_switch_output;
	assign main_status_indicator = st_ff.safety_switch_output;
	assign lock_red_indicator = !st_ff.safety_switch_output;
	assign ready_yellow_indicator = st_ff.yellow;
	assign button_in_lamp_out_pin_out = !st_ff.safety_switch_output;
	assign button_in_lamp_out_pin_oe_n = release_slot;
	assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_safety_switch_output_only_on;
		safety_switch_output_a |-> $past(st_ff.state) == RILRT_ON && safety_switch_output_b;
	endproperty
	a_safety_switch_output_only_on: assert property (p_safety_switch_output_only_on) else $error("outputs on outside ON state");

	property p_red_while_off;
		!safety_switch_output_a |-> lock_red_indicator && !main_status_indicator;
	endproperty
	a_red_while_off: assert property (p_red_while_off) else $error("red not lit with outputs off");

	property p_yellow_pending;
		(st_ff.state == RILRT_LOCKED && field_clear && lock_en) |=> ready_yellow_indicator;
	endproperty
	a_yellow_pending: assert property (p_yellow_pending) else $error("yellow not lit while pending");

	property p_valid_unlock;
		(valid_press && st_ff.state == RILRT_LOCKED && field_clear && lock_en)
			|=> st_ff.state == RILRT_ON ##1 (safety_switch_output_a || !$past(field_clear));
	endproperty
	a_valid_unlock: assert property (p_valid_unlock) else $error("valid press did not unlock");

	property p_long_ignored;
		(ignored_press && st_ff.state == RILRT_LOCKED && lock_en) |=> st_ff.state == RILRT_LOCKED;
	endproperty
	a_long_ignored: assert property (p_long_ignored) else $error("long press unlocked");

	property p_stuck_fault;
		(tick && st_ff.btn && st_ff.press == STUCK_T - PW'(1)) |=> st_ff.state == RILRT_FAULT ##1 !safety_switch_output_a;
	endproperty
	a_stuck_fault: assert property (p_stuck_fault) else $error("stuck button not faulted");

	property p_on_clear;
		(st_ff.state == RILRT_ON && field_clear && !stuck) |=> safety_switch_output_a && main_status_indicator;
	endproperty
	a_on_clear: assert property (p_on_clear) else $error("outputs off in clear ON state");

	property p_pin_sample;
		tick |-> button_in_lamp_out_pin_oe_n && button_in_lamp_out_pin_out == !safety_switch_output_a;
	endproperty
	a_pin_sample: assert property (p_pin_sample) else $error("pin driven at sample point");

	property p_press_timebase;
		!tick |=> $stable(st_ff.press);
	endproperty
	a_press_timebase: assert property (p_press_timebase) else $error("press count off time base");

	c_unlock: cover property (valid_press && st_ff.state == RILRT_LOCKED ##1 st_ff.state == RILRT_ON);
	c_fault: cover property (st_ff.state == RILRT_ON ##1 st_ff.state == RILRT_FAULT);
	c_ignored: cover property (ignored_press && st_ff.state == RILRT_LOCKED);
	c_trip: cover property (safety_switch_output_a ##1 st_ff.state == RILRT_LOCKED);
endmodule // rilrt_top
`default_nettype wire
